// ==== include/rcf_pkg.sv ====
package rcf_pkg;
	localparam int RCF_DATA_W = 32;
	localparam int RCF_ADDR_W = 4;
	// Byte addresses of the word registers
	localparam logic [3:0] RCF_OFF_FLAGS = 4'h0;
	localparam logic [3:0] RCF_OFF_STBY = 4'h4;
	localparam logic [3:0] RCF_OFF_IRQ_STAT = 4'h8;
	localparam logic [3:0] RCF_OFF_IRQ_MASK = 4'hc;
	// Flag bit positions
	localparam int RCF_BIT_SW = 0;
	localparam int RCF_BIT_HW = 1;
	localparam int RCF_BIT_PWR = 2;
	localparam int RCF_BIT_DOG = 3;
	localparam int RCF_BIT_PIN = 4;
	localparam int RCF_FLAG_W = 5;
	localparam int RCF_BIT_SWREQ = 0;
	localparam logic [4:0] RCF_FLAGS_RST = 5'h00;
	localparam logic [4:0] RCF_MASK_RST = 5'h00;
	// Length of the internal reset pulse caused by the software request
	localparam int RCF_SWRST_CYC = 4;
	localparam logic [31:0] RCF_UNMAPPED_RD = 32'h0000_0000;
	typedef enum {RCF_IDLE, RCF_RDWAIT} rcf_bus_t;
endpackage : rcf_pkg

// ==== hdl/rcf_reset_cause_flag_register.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_flag_register
	import rcf_pkg::*;
#(
	parameter int SWRST_CYC = RCF_SWRST_CYC
) (
	input wire logic clk, // Machine clock
	input wire logic rst, // Power-on or low-voltage reset, async high
	input wire logic pin_reset_evt, // Filtered external pin reset, one cycle
	input wire logic dog_timeout_evt, // Watchdog overflow, one cycle
	input wire logic [RCF_ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [RCF_DATA_W-1:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [RCF_DATA_W-1:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	output logic sw_reset_out, // Software reset to the system, level
	output logic irq // Interrupt, level
);
	initial begin
		if (SWRST_CYC < 1 || SWRST_CYC > 255) $error("SWRST_CYC out of range");
	end

	// Flags are reset only by power-on or by a read or write of the flag register; other resets hold them
	logic [RCF_FLAG_W-1:0] flags_reg, flags_next;
	logic [RCF_FLAG_W-1:0] stat_reg, stat_next;
	logic [RCF_FLAG_W-1:0] mask_reg, mask_next;
	logic [7:0] swcnt_reg, swcnt_next;
	logic [RCF_DATA_W-1:0] rdata_reg, rdata_next;
	rcf_bus_t bus_reg, bus_next;
	logic por_pend_reg, por_pend_next;
	logic wr_en;
	logic sw_evt;

	function automatic logic hit(input logic [RCF_ADDR_W-1:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	// Read answers one cycle after the request; writes complete at once
	assign wr_en = avs_write && avs_byteenable[0];
	assign avs_waitrequest = avs_read && bus_reg == RCF_IDLE;
	assign sw_evt = swcnt_reg == 8'(1);
	assign sw_reset_out = swcnt_reg != 8'h00;
	assign avs_readdata = rdata_reg;
	assign irq = |(stat_reg & mask_reg);

	always_comb begin
		logic [RCF_FLAG_W-1:0] ev;
		ev = '0;
		flags_next = flags_reg;
		stat_next = stat_reg;
		mask_next = mask_reg;
		swcnt_next = swcnt_reg;
		rdata_next = rdata_reg;
		bus_next = bus_reg;
		por_pend_next = 1'b0;
		// Software clears happen first so that a coinciding reset wins
		if (avs_write && hit(avs_address, RCF_OFF_FLAGS) && wr_en)
			flags_next = '0;
		if (avs_read && bus_reg == RCF_IDLE && hit(avs_address, RCF_OFF_FLAGS))
			flags_next = '0;
		if (por_pend_reg) begin
			flags_next[RCF_BIT_PWR] = 1'b1;
			flags_next[RCF_BIT_HW] = 1'b1;
			flags_next[RCF_BIT_SW] = 1'b0;
			ev[RCF_BIT_PWR] = 1'b1;
		end
		if (pin_reset_evt) begin
			flags_next[RCF_BIT_PIN] = 1'b1;
			flags_next[RCF_BIT_HW] = 1'b1;
			ev[RCF_BIT_PIN] = 1'b1;
		end
		if (dog_timeout_evt) begin
			flags_next[RCF_BIT_DOG] = 1'b1;
			flags_next[RCF_BIT_HW] = 1'b1;
			ev[RCF_BIT_DOG] = 1'b1;
		end
		if (sw_evt) begin
			flags_next[RCF_BIT_SW] = 1'b1;
			ev[RCF_BIT_SW] = 1'b1;
		end
		ev[RCF_BIT_HW] = ev[RCF_BIT_PWR] | ev[RCF_BIT_PIN] | ev[RCF_BIT_DOG];
		// Software reset request pulse
		if (swcnt_reg != 8'h00)
			swcnt_next = swcnt_reg - 8'(1);
		else if (avs_write && hit(avs_address, RCF_OFF_STBY) && wr_en && avs_writedata[RCF_BIT_SWREQ])
			swcnt_next = 8'(SWRST_CYC);
		if (avs_write && hit(avs_address, RCF_OFF_IRQ_MASK) && wr_en)
			mask_next = avs_writedata[RCF_FLAG_W-1:0];
		// Bus read path; status read clears, new events win
		case (bus_reg)
			RCF_IDLE: begin
				if (avs_read) begin
					bus_next = RCF_RDWAIT;
					if (hit(avs_address, RCF_OFF_FLAGS))
						rdata_next = {27'h0, flags_reg};
					else if (hit(avs_address, RCF_OFF_STBY))
						rdata_next = {31'h0, sw_reset_out};
					else if (hit(avs_address, RCF_OFF_IRQ_STAT)) begin
						rdata_next = {27'h0, stat_reg};
						stat_next = '0;
					end else if (hit(avs_address, RCF_OFF_IRQ_MASK))
						rdata_next = {27'h0, mask_reg};
					else
						rdata_next = RCF_UNMAPPED_RD;
				end
			end
			RCF_RDWAIT: begin
				bus_next = RCF_IDLE;
			end
			default: begin
				bus_next = RCF_IDLE;
			end
		endcase
		stat_next = stat_next | ev;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_reg <= RCF_FLAGS_RST;
			stat_reg <= RCF_FLAGS_RST;
			mask_reg <= RCF_MASK_RST;
			swcnt_reg <= 8'h00;
			rdata_reg <= '0;
			bus_reg <= RCF_IDLE;
			por_pend_reg <= 1'b1;
		end else begin
			flags_reg <= flags_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			swcnt_reg <= swcnt_next;
			rdata_reg <= rdata_next;
			bus_reg <= bus_next;
			por_pend_reg <= por_pend_next;
		end
	end
endmodule : rcf_reset_cause_flag_register
`default_nettype wire

// ==== dv/rcf_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcf_chk (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic pin_reset_evt, // pin
	input wire logic dog_timeout_evt, // dog
	input wire logic [3:0] avs_address, // addr
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic [31:0] avs_writedata, // wdata
	input wire logic [31:0] avs_readdata, // rdata
	input wire logic avs_waitrequest, // stall
	input wire logic sw_reset_out, // soft reset
	input wire logic irq // irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rd0 = avs_read && avs_address == 4'h0 && !avs_waitrequest;
	upper_zero_a: assert property (rd0 |-> avs_readdata[31:5] == 0) else $error("upper bits");
	pin_flag_a: assert property (pin_reset_evt ##1 $rose(avs_read) ##1 rd0 |-> avs_readdata[4] && avs_readdata[1])
		else $error("pin flag");
	dog_flag_a: assert property (dog_timeout_evt ##1 $rose(avs_read) ##1 rd0 |-> avs_readdata[3] && avs_readdata[1])
		else $error("dog flag");
	rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("rd wait");
	wr_nowait_a: assert property (avs_write |-> !avs_waitrequest) else $error("wr wait");
	sw_req_a: assert property (avs_write && avs_address == 4'h4 && avs_writedata[0] && !sw_reset_out |=> sw_reset_out)
		else $error("sw req");
	sw_len_a: assert property ($rose(sw_reset_out) |-> sw_reset_out[*4] ##1 !sw_reset_out) else $error("sw len");
	irq_off_a: assert property (avs_write && avs_address == 4'hc && avs_writedata[4:0] == 0 |=> !irq)
		else $error("irq mask");
endmodule : rcf_chk
bind rcf_reset_cause_flag_register rcf_chk i_rcf_chk (.clk, .rst, .pin_reset_evt, .dog_timeout_evt, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sw_reset_out, .irq);
`default_nettype wire

// ==== dv/rcf_reset_cause_flag_register_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_flag_register_bench;
	logic clk = 0, rst = 1, pin = 0, dog = 0, rd_en = 0, wr_en = 0, wt, software_reset_flag, irq;
	logic [3:0] adr = 0;
	logic [31:0] wd = 0, rdat, d;
	int num_errors = 0, compares = 0;
	rcf_reset_cause_flag_register i_rcf_reset_cause_flag_register (.clk, .rst, .pin_reset_evt(pin),
		.dog_timeout_evt(dog), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wd),
		.avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt), .sw_reset_out(software_reset_flag), .irq);
	initial forever #2.5 clk = ~clk;
	initial begin
		#20000;
		num_errors++;
		close_out();
	end
	task close_out;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		adr <= a;
		wd <= v;
		if (w) wr_en <= 1;
		else rd_en <= 1;
		do begin
			@(posedge clk);
		end while (wt !== 1'b0);
		d = rdat;
		wr_en <= 0;
		rd_en <= 0;
		@(posedge clk);
	endtask : bus
	task rc(input logic [3:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(d, e);
	endtask : rc
	task ev(input logic w);
		if (w) dog <= 1;
		else pin <= 1;
		@(posedge clk);
		pin <= 0;
		dog <= 0;
	endtask : ev
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		rc(4'h0, 32'h06);
		rc(4'h0, 0);
		rc(4'h8, 32'h06);
		ev(0);
		rc(4'h0, 32'h12);
		ev(1);
		rc(4'h0, 32'h0a);
		ev(0);
		ev(1);
		rc(4'h0, 32'h1a);
		rc(4'h8, 32'h1a);
		ev(1);
		@(posedge clk);
		chk(irq, 0);
		bus(1, 4'hc, 32'h08);
		chk(irq, 1);
		rc(4'h8, 32'h0a);
		chk(irq, 0);
		bus(1, 4'h4, 1);
		chk(software_reset_flag, 1);
		repeat (6) @(posedge clk);
		chk(software_reset_flag, 0);
		ev(0);
		rc(4'h0, 32'h1b);
		ev(1);
		bus(1, 4'h0, 32'hff);
		rc(4'h0, 0);
		ev(0);
		bus(1, 4'h0, 0);
		rc(4'h0, 0);
		rc(4'h2, 0);
		bus(1, 4'hc, 0);
		chk(irq, 0);
		bus(1, 4'h4, 1);
		repeat (6) @(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		rc(4'h0, 32'h06);
		close_out();
	end
endmodule : rcf_reset_cause_flag_register_bench
`default_nettype wire
